// *** rtl/sabc_defs.svh ***
`ifndef SABC_DEFS_SVH
`define SABC_DEFS_SVH
// timing figures in ns, cycle counts derived from the 100 ns clock
`define SABC_CLK_NS 100
`define SABC_STS_RISE_NS 200
`define SABC_STS_FALL_NS 600
`define SABC_EARLY_READ_NS 1200
`define SABC_STS_RISE_CYC ((`SABC_STS_RISE_NS + `SABC_CLK_NS - 1) / `SABC_CLK_NS)
`define SABC_STS_FALL_CYC (`SABC_STS_FALL_NS / `SABC_CLK_NS)
`define SABC_EARLY_READ_CYC (`SABC_EARLY_READ_NS / `SABC_CLK_NS)
// approximation steps for each conversion length
`define SABC_STEPS_LONG 12
`define SABC_STEPS_SHORT 8
// byte format field positions
`define SABC_HI_BYTE_MSB 11
`define SABC_HI_BYTE_LSB 4
`define SABC_LO_NIB_MSB 3
`define SABC_LO_NIB_LSB 0
`define SABC_RESULT_RST 12'h000
`endif

// *** rtl/sabc_pkg.sv ***
package sabc_pkg;
   typedef enum logic [2:0] {
      SABC_IDLE = 3'b000,
      SABC_LEAD = 3'b001,
      SABC_APPROX = 3'b011,
      SABC_TAIL = 3'b010
   } sabc_state_t;
   typedef struct packed {
      logic chip_en;
      logic chip_sel_n;
      logic read_conv;
      logic word_fmt;
      logic byte_length_sel;
   } sabc_ctl_t;
endpackage

// *** rtl/sabc_sar.sv ***
`timescale 1ns/1ps
`include "sabc_defs.svh"
module sabc_sar
   import sabc_pkg::*;
#(
   parameter int WIDTH = 12
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // control
   input wire logic start,
   input wire logic short_conv,
   input wire logic [WIDTH-1:0] sample,
   // result
   output logic done,
   output logic [WIDTH-1:0] result
);
   logic [WIDTH-1:0] trial_r;
   logic [WIDTH-1:0] bit_r;
   logic [WIDTH-1:0] stop_r;

   // one bit per step, msb first; comparator modelled digitally
   always_ff @(posedge mclk) begin
      if (srst) begin
         trial_r <= '0;
         bit_r <= '0;
         stop_r <= '0;
         done <= 1'b0;
         result <= `SABC_RESULT_RST;
      end else begin
         done <= 1'b0;
         if (start) begin
            bit_r <= {1'b1, {(WIDTH-1){1'b0}}};
            trial_r <= '0;
            // mask of the last bit to resolve; short runs stop above the low bits
            stop_r <= short_conv ? WIDTH'(1) << (WIDTH - `SABC_STEPS_SHORT) : WIDTH'(1);
         end else if (bit_r != '0) begin
            if ((trial_r | bit_r) <= sample)
               trial_r <= trial_r | bit_r;
            bit_r <= bit_r >> 1;
            if ((bit_r & stop_r) != '0) begin
               bit_r <= '0;
               done <= 1'b1;
               result <= ((trial_r | bit_r) <= sample) ? (trial_r | bit_r) : trial_r;
            end
         end
      end
   end
endmodule

// *** rtl/sabc_ctrl.sv ***
`timescale 1ns/1ps
`include "sabc_defs.svh"
module sabc_ctrl
   import sabc_pkg::*;
#(
   parameter int WIDTH = 12
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // bus control pins
   input wire sabc_ctl_t ctl,
   // analog stand-in
   input wire logic [WIDTH-1:0] sample,
   // data lines, enable low while driving
   output logic [WIDTH-1:0] data_out,
   output logic [WIDTH-1:0] data_oe_n,
   // status
   output logic conversion_in_progress
);
   sabc_state_t state_r;
   logic enabled;
   logic conv_req;
   logic read_req;
   logic enabled_d_r;
   logic read_conv_d_r;
   logic short_r;
   logic sar_start_r;
   logic sar_done;
   logic [WIDTH-1:0] sar_result;
   logic [WIDTH-1:0] result_r;
   logic [3:0] cnt_r;
   logic [WIDTH-1:0] out_nxt;
   logic [WIDTH-1:0] oe_n_nxt;

   function automatic logic [WIDTH-1:0] pack_byte(input logic [WIDTH-1:0] r, input logic odd);
      logic [WIDTH-1:0] b;
      b = '0;
      if (odd)
         b[7:0] = {r[`SABC_LO_NIB_MSB:`SABC_LO_NIB_LSB], 4'h0};
      else
         b[7:0] = r[`SABC_HI_BYTE_MSB:`SABC_HI_BYTE_LSB];
      return b;
   endfunction

   assign enabled = ctl.chip_en && !ctl.chip_sel_n;
   // start on entry to the enabled condition with read low, or read falling while enabled
   assign conv_req = enabled && !ctl.read_conv &&
                     (!enabled_d_r || read_conv_d_r);
   assign read_req = enabled && ctl.read_conv;

   always_ff @(posedge mclk) begin
      if (srst) begin
         enabled_d_r <= 1'b0;
         read_conv_d_r <= 1'b0;
      end else begin
         enabled_d_r <= enabled;
         read_conv_d_r <= ctl.read_conv;
      end
   end

   // conversion sequencer
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_r <= SABC_IDLE;
         cnt_r <= 4'h0;
         short_r <= 1'b0;
         sar_start_r <= 1'b0;
         conversion_in_progress <= 1'b0;
      end else begin
         sar_start_r <= 1'b0;
         case (state_r)
            SABC_IDLE: begin
               if (conv_req) begin
                  short_r <= ctl.byte_length_sel;
                  cnt_r <= 4'(`SABC_STS_RISE_CYC - 1);
                  state_r <= SABC_LEAD;
               end
            end
            SABC_LEAD: begin
               if (cnt_r == 4'h0) begin
                  conversion_in_progress <= 1'b1;
                  sar_start_r <= 1'b1;
                  state_r <= SABC_APPROX;
               end else
                  cnt_r <= cnt_r - 4'h1;
            end
            SABC_APPROX: begin
               if (sar_done) begin
                  cnt_r <= 4'(`SABC_STS_FALL_CYC - 1);
                  state_r <= SABC_TAIL;
               end
            end
            SABC_TAIL: begin
               // data already valid here, so reads during this tail are honoured
               if (cnt_r == 4'h0) begin
                  conversion_in_progress <= 1'b0;
                  state_r <= SABC_IDLE;
               end else
                  cnt_r <= cnt_r - 4'h1;
            end
            default: state_r <= SABC_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst)
         result_r <= `SABC_RESULT_RST;
      else if (sar_done)
         result_r <= sar_result;
   end

   sabc_sar #(.WIDTH(WIDTH)) u_sar (
      .mclk(mclk),
      .srst(srst),
      .start(sar_start_r),
      .short_conv(short_r),
      .sample(sample),
      .done(sar_done),
      .result(sar_result)
   );

   // output buffers: float while converting, read allowed in the tail window
   always_comb begin
      out_nxt = '0;
      oe_n_nxt = '1;
      if (read_req && !conv_req &&
          (state_r == SABC_IDLE || state_r == SABC_TAIL)) begin
         if (ctl.word_fmt) begin
            out_nxt = result_r;
            oe_n_nxt = '0;
         end else begin
            out_nxt = pack_byte(result_r, ctl.byte_length_sel);
            oe_n_nxt = {{(WIDTH-8){1'b1}}, 8'h00};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         data_out <= '0;
         data_oe_n <= '1;
      end else begin
         data_out <= out_nxt;
         data_oe_n <= oe_n_nxt;
      end
   end

   a_sts_rise: assert property (@(posedge mclk) disable iff (srst)
      (state_r == SABC_IDLE && conv_req) |-> ##(`SABC_STS_RISE_CYC + 1)
      conversion_in_progress)
      else $error("status did not rise after start");
   a_float_busy: assert property (@(posedge mclk) disable iff (srst)
      (state_r == SABC_APPROX) |=> data_oe_n == '1)
      else $error("outputs driven during conversion");
   a_byte_zero: assert property (@(posedge mclk) disable iff (srst)
      (read_req && !ctl.word_fmt && ctl.byte_length_sel && state_r == SABC_IDLE && !conv_req)
      |=> data_out[3:0] == 4'h0 && data_oe_n[7:0] == 8'h00)
      else $error("odd byte trailing zeros wrong");
   a_ignore_busy: assert property (@(posedge mclk) disable iff (srst)
      (state_r == SABC_APPROX) |=> state_r != SABC_LEAD)
      else $error("start accepted while busy");
   a_sts_fall: assert property (@(posedge mclk) disable iff (srst)
      (state_r == SABC_TAIL && cnt_r == 4'h0) |=> !conversion_in_progress)
      else $error("status did not fall at cycle end");
   a_word_drive: assert property (@(posedge mclk) disable iff (srst)
      (read_req && ctl.word_fmt && state_r == SABC_IDLE && !conv_req)
      |=> data_oe_n == '0 && data_out == result_r)
      else $error("word read not driven");
endmodule

// *** tb/sabc_bus_model.sv ***
`timescale 1ns/1ps
module sabc_bus_model (
   // clock
   input wire logic mclk,
   // device pins
   input wire logic [11:0] data_out,
   input wire logic [11:0] data_oe_n,
   // host view
   output logic [15:0] host_word
);
   logic [15:0] float_r = 16'h5a5a;
   logic [15:0] bus;
   // undriven lines keep changing so a float never reads as a match
   always_ff @(posedge mclk) begin
      float_r <= ~float_r;
   end
   always_comb begin
      bus = float_r;
      for (int i = 0; i < 12; i++) begin
         if (data_oe_n[i] === 1'b0) begin
            bus[i] = data_out[i];
         end
      end
   end
   assign host_word = bus & 16'h0fff;
endmodule

// *** tb/sabc_ctrl_tb.sv ***
`timescale 1ns/1ps
module sabc_ctrl_tb;
   import sabc_pkg::*;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   sabc_ctl_t ctl = 5'b01110;
   logic [11:0] sample = 12'ha5c;
   logic [11:0] data_out;
   logic [11:0] data_oe_n;
   logic conversion_in_progress;
   logic [15:0] host_word;
   int fail_count = 0;
   int n_tests = 0;
   int n;
   initial begin
      forever #50 mclk = ~mclk;
   end
   sabc_ctrl sabc_ctrl_inst (.mclk(mclk), .srst(srst), .ctl(ctl), .sample(sample),
      .data_out(data_out), .data_oe_n(data_oe_n),
      .conversion_in_progress(conversion_in_progress));
   sabc_bus_model sabc_bus_model_inst (.mclk(mclk), .data_out(data_out),
      .data_oe_n(data_oe_n), .host_word(host_word));
   task check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task drv(input logic ce, csn, rc, wf, bl);
      @(posedge mclk);
      ctl <= {ce, csn, rc, wf, bl};
   endtask
   // bounded wait, so a stuck status ends the run
   task wait_idle;
      n = 0;
      while (conversion_in_progress !== 1'b0 && n < 200) begin
         tick(1);
         n++;
      end
      if (n >= 200) begin
         fail_count++;
         wrap_up;
      end
   endtask
   task rd(input logic wf, bl, input logic [11:0] exp_oe, exp);
      drv(1, 0, 1, wf, bl);
      tick(2);
      check(data_oe_n, exp_oe);
      check(data_out & ~exp_oe, exp);
      if (wf) check(host_word, {4'h0, exp});
      drv(1, 1, 1, wf, bl);
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      tick(1);
      check(data_oe_n, 12'hfff);
      check(conversion_in_progress, 1'b0);
      // convert low before enabling, chip select completes it
      drv(0, 1, 0, 1, 0);
      drv(1, 1, 0, 1, 0);
      drv(1, 0, 0, 1, 0);
      tick(2);
      check(conversion_in_progress, 1'b0);
      tick(1);
      check(conversion_in_progress, 1'b1);
      drv(1, 0, 1, 1, 0);
      tick(2);
      check(data_oe_n, 12'hfff);
      drv(1, 1, 0, 1, 0);
      drv(1, 0, 0, 1, 0);
      wait_idle;
      tick(10);
      check(conversion_in_progress, 1'b0);
      drv(1, 1, 1, 1, 0);
      rd(1, 0, 12'h000, 12'ha5c);
      rd(0, 0, 12'hf00, 12'h0a5);
      rd(0, 1, 12'hf00, 12'h0c0);
      drv(1, 1, 0, 1, 1);
      drv(1, 0, 0, 1, 1);
      tick(4);
      wait_idle;
      drv(1, 1, 1, 1, 0);
      rd(1, 0, 12'h000, 12'ha50);
      // standalone wiring, low pulse
      drv(1, 0, 1, 1, 0);
      tick(2);
      check(data_oe_n, 12'h000);
      drv(1, 0, 0, 1, 0);
      drv(1, 0, 1, 1, 0);
      tick(1);
      check(data_oe_n, 12'hfff);
      n = 0;
      while (data_oe_n !== 12'h000 && n < 200) begin
         tick(1);
         n++;
      end
      if (n >= 200) begin
         fail_count++;
         wrap_up;
      end
      check(conversion_in_progress, 1'b1);
      check(data_out, 12'ha5c);
      n = 0;
      while (conversion_in_progress !== 1'b0 && n < 20) begin
         tick(1);
         n++;
      end
      if (n >= 20) begin
         fail_count++;
         wrap_up;
      end
      // one cycle of register slack allowed
      check(n >= 5 && n <= 6, 1'b1);
      // high pulse: the fall starts, lines float while low
      drv(1, 0, 0, 1, 0);
      tick(2);
      check(data_oe_n, 12'hfff);
      tick(4);
      wait_idle;
      tick(2);
      check(data_oe_n, 12'hfff);
      wrap_up;
   end
endmodule
